// ===== rtl/fcp_pkg.sv
// Package of register offsets, field positions and reset values for the four-channel modulator
package fcp_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_CHAN2_DUTY_LOW = 8'hDD;
    localparam logic [7:0] ADDR_CHAN3_DUTY_LOW = 8'hDE;
    localparam logic [7:0] ADDR_BRAKE_OUT_CTRL = 8'hDF;
    localparam logic [7:0] ADDR_MAIN_CTRL = 8'hDC;
    localparam logic [7:0] ADDR_PERIOD_LOW = 8'hD0;
    localparam logic [7:0] ADDR_PERIOD_HIGH = 8'hD1;
    localparam logic [7:0] ADDR_CHAN0_DUTY_LOW = 8'hD2;
    localparam logic [7:0] ADDR_CHAN1_DUTY_LOW = 8'hD3;
    localparam logic [7:0] ADDR_CHAN0_DUTY_HIGH = 8'hD4;
    localparam logic [7:0] ADDR_CHAN1_DUTY_HIGH = 8'hD5;
    localparam logic [7:0] ADDR_CHAN2_DUTY_HIGH = 8'hD6;
    localparam logic [7:0] ADDR_CHAN3_DUTY_HIGH = 8'hD7;

    // ****************************************
    // Main control and brake control fields
    // ****************************************
    localparam int CTRL_RUN_BIT = 7;
    localparam int CTRL_LOAD_BIT = 6;
    localparam int CTRL_UFLOW_BIT = 5;
    localparam int CTRL_CLEAR_BIT = 4;
    localparam int BRAKE_FLAG_BIT = 7;
    localparam int BRAKE_EN_BIT = 4;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int CNT_W = 10;
    localparam int NUM_CH = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_RESET = 10'h000;
endpackage

// ===== rtl/fcp_chan.sv
// One modulator channel: duty compare and output polarity
`timescale 1ns/10ps
module fcp_chan
    import fcp_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Compare inputs
    input wire logic [W-1:0] count_i,
    input wire logic [W-1:0] duty_i,
    input wire logic invert_i,
    // Channel output
    output logic out_o
);

    logic out_r;
    logic cmp_nxt;

    // Compare, then apply polarity
    always_comb
    begin
        cmp_nxt = (count_i < duty_i);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            out_r <= 1'b0;
        else
            out_r <= cmp_nxt ^ invert_i;
    end

    assign out_o = out_r;
endmodule

// ===== rtl/fcp_core.sv
// Four-channel 10-bit modulator with special function register port
`timescale 1ns/10ps
module fcp_core
    import fcp_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // Brake input and interrupt request
    input wire logic brake_i,
    output logic brake_irq_o,
    // Modulator outputs
    output logic [NUM_CH-1:0] pwm_o
);

    // ****************************************
    // Register state
    // ****************************************
    logic counter_run_r;
    logic load_req_r;
    logic underflow_flag_r;
    logic counter_clear_req_r;
    logic [NUM_CH-1:0] chan_invert_r;
    logic [7:0] brake_and_output_ctrl_r;
    logic brake_event_flag_r;
    logic [W-1:0] period_value_r;
    logic [W-1:0] channel_duty_value_r [NUM_CH];
    logic [W-1:0] cmp_r [NUM_CH];
    logic [W-1:0] cmp_period_r;
    logic [W-1:0] count_r;
    logic load_pend_r;
    logic [7:0] sfr_rdata_r;
    logic underflow;
    logic wr_main;

    assign wr_main = sfr_wr_i && (sfr_addr_i == ADDR_MAIN_CTRL);
    assign underflow = counter_run_r && (count_r == CNT_ZERO);

    // ****************************************
    // Main control register
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            counter_run_r <= 1'b0;
            chan_invert_r <= '0;
        end
        else if (wr_main)
        begin
            counter_run_r <= sfr_wdata_i[CTRL_RUN_BIT];
            chan_invert_r <= sfr_wdata_i[NUM_CH-1:0];
        end
    end

    // Load request lasts one cycle, held pending until underflow
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            load_req_r <= 1'b0;
            load_pend_r <= 1'b0;
        end
        else
        begin
            load_req_r <= wr_main && sfr_wdata_i[CTRL_LOAD_BIT];
            if (load_req_r)
                load_pend_r <= 1'b1;
            else if (underflow)
                load_pend_r <= 1'b0;
        end
    end

    // Underflow flag: set wins over software clear
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            underflow_flag_r <= 1'b0;
        else if (underflow)
            underflow_flag_r <= 1'b1;
        else if (wr_main && !sfr_wdata_i[CTRL_UFLOW_BIT])
            underflow_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            counter_clear_req_r <= 1'b0;
        else
            counter_clear_req_r <= wr_main && sfr_wdata_i[CTRL_CLEAR_BIT];
    end

    // ****************************************
    // Period and duty holding registers
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            period_value_r <= CNT_RESET;
            for (int i = 0; i < NUM_CH; i++)
                channel_duty_value_r[i] <= CNT_RESET;
        end
        else if (sfr_wr_i)
        begin
            case (sfr_addr_i)
                ADDR_PERIOD_LOW: period_value_r[7:0] <= sfr_wdata_i;
                ADDR_PERIOD_HIGH: period_value_r[W-1:8] <= sfr_wdata_i[W-9:0];
                ADDR_CHAN0_DUTY_LOW: channel_duty_value_r[0][7:0] <= sfr_wdata_i;
                ADDR_CHAN1_DUTY_LOW: channel_duty_value_r[1][7:0] <= sfr_wdata_i;
                ADDR_CHAN2_DUTY_LOW: channel_duty_value_r[2][7:0] <= sfr_wdata_i;
                ADDR_CHAN3_DUTY_LOW: channel_duty_value_r[3][7:0] <= sfr_wdata_i;
                ADDR_CHAN0_DUTY_HIGH: channel_duty_value_r[0][W-1:8] <= sfr_wdata_i[W-9:0];
                ADDR_CHAN1_DUTY_HIGH: channel_duty_value_r[1][W-1:8] <= sfr_wdata_i[W-9:0];
                ADDR_CHAN2_DUTY_HIGH: channel_duty_value_r[2][W-1:8] <= sfr_wdata_i[W-9:0];
                ADDR_CHAN3_DUTY_HIGH: channel_duty_value_r[3][W-1:8] <= sfr_wdata_i[W-9:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Brake control and flag
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            brake_and_output_ctrl_r <= REG_RESET;
        else if (sfr_wr_i && (sfr_addr_i == ADDR_BRAKE_OUT_CTRL))
            brake_and_output_ctrl_r <= sfr_wdata_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            brake_event_flag_r <= 1'b0;
        else if (brake_i && brake_and_output_ctrl_r[BRAKE_EN_BIT])
            brake_event_flag_r <= 1'b1;
        else if (sfr_wr_i && (sfr_addr_i == ADDR_BRAKE_OUT_CTRL) && !sfr_wdata_i[BRAKE_FLAG_BIT])
            brake_event_flag_r <= 1'b0;
    end

    assign brake_irq_o = brake_event_flag_r;

    // ****************************************
    // Shared down counter and compare load
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            count_r <= CNT_RESET;
        else if (counter_clear_req_r)
            count_r <= CNT_ZERO;
        else if (underflow)
            count_r <= load_pend_r ? period_value_r : cmp_period_r;
        else if (counter_run_r)
            count_r <= count_r - 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            cmp_period_r <= CNT_RESET;
            for (int i = 0; i < NUM_CH; i++)
                cmp_r[i] <= CNT_RESET;
        end
        else if (underflow && load_pend_r)
        begin
            cmp_period_r <= period_value_r;
            for (int i = 0; i < NUM_CH; i++)
                cmp_r[i] <= channel_duty_value_r[i];
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_chan
            fcp_chan #(
                .W(W)
            ) u_chan (
                .ref_clk_i(ref_clk_i),
                .srst_i(srst_i),
                .count_i(count_r),
                .duty_i(cmp_r[g]),
                .invert_i(chan_invert_r[g]),
                .out_o(pwm_o[g])
            );
        end
    endgenerate

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            sfr_rdata_r <= REG_RESET;
        else if (sfr_rd_i)
        begin
            case (sfr_addr_i)
                ADDR_MAIN_CTRL: sfr_rdata_r <= {counter_run_r, load_req_r, underflow_flag_r,
                    counter_clear_req_r, chan_invert_r};
                ADDR_PERIOD_LOW: sfr_rdata_r <= period_value_r[7:0];
                ADDR_PERIOD_HIGH: sfr_rdata_r <= {6'h00, period_value_r[W-1:8]};
                ADDR_CHAN0_DUTY_LOW: sfr_rdata_r <= channel_duty_value_r[0][7:0];
                ADDR_CHAN1_DUTY_LOW: sfr_rdata_r <= channel_duty_value_r[1][7:0];
                ADDR_CHAN2_DUTY_LOW: sfr_rdata_r <= channel_duty_value_r[2][7:0];
                ADDR_CHAN3_DUTY_LOW: sfr_rdata_r <= channel_duty_value_r[3][7:0];
                ADDR_CHAN0_DUTY_HIGH: sfr_rdata_r <= {6'h00, channel_duty_value_r[0][W-1:8]};
                ADDR_CHAN1_DUTY_HIGH: sfr_rdata_r <= {6'h00, channel_duty_value_r[1][W-1:8]};
                ADDR_CHAN2_DUTY_HIGH: sfr_rdata_r <= {6'h00, channel_duty_value_r[2][W-1:8]};
                ADDR_CHAN3_DUTY_HIGH: sfr_rdata_r <= {6'h00, channel_duty_value_r[3][W-1:8]};
                ADDR_BRAKE_OUT_CTRL: sfr_rdata_r <= {brake_event_flag_r, brake_and_output_ctrl_r[6:0]};
                default: sfr_rdata_r <= REG_RESET;
            endcase
        end
    end

    assign sfr_rdata_o = sfr_rdata_r;
endmodule

// ===== dv/fcp_core_props.sv
// Port checker for the modulator core
`timescale 1ns/10ps
module fcp_core_props
    import fcp_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    // Brake and outputs
    input wire logic brake_i,
    input wire logic brake_irq_o,
    input wire logic [NUM_CH-1:0] pwm_o
);
    logic [7:0] dd_r;
    logic ben_r;
    logic run_r;
    logic cw;
    logic rc;
    assign cw = sfr_wr_i && sfr_addr_i == ADDR_MAIN_CTRL;
    assign rc = sfr_rd_i && sfr_addr_i == ADDR_MAIN_CTRL;
    // ****
    // Shadows of written values
    // ****
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            dd_r <= REG_RESET;
            ben_r <= 1'b0;
            run_r <= 1'b0;
        end
        else if (sfr_wr_i)
        begin
            if (sfr_addr_i == ADDR_CHAN2_DUTY_LOW)
                dd_r <= sfr_wdata_i;
            if (sfr_addr_i == ADDR_BRAKE_OUT_CTRL)
                ben_r <= sfr_wdata_i[BRAKE_EN_BIT];
            if (cw)
                run_r <= sfr_wdata_i[CTRL_RUN_BIT];
        end
    end
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    // ****
    // Assertions
    // ****
    chk_chan2_low_read: assert property (
        sfr_rd_i && sfr_addr_i == ADDR_CHAN2_DUTY_LOW |=> sfr_rdata_o == dd_r) else $error("chan2 low read");
    chk_unmapped_zero: assert property (
        sfr_rd_i && sfr_addr_i inside {[8'hD8:8'hDB]} |=> sfr_rdata_o == 8'h00) else $error("unmapped read");
    chk_rdata_hold: assert property (
        !sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved");
    chk_load_self_clear: assert property (
        rc && !$past(cw && sfr_wdata_i[CTRL_LOAD_BIT]) |=> !sfr_rdata_o[CTRL_LOAD_BIT]) else $error("load bit stuck");
    chk_clear_self_clear: assert property (
        rc && !$past(cw, 1) && !$past(cw, 2) |=> !sfr_rdata_o[CTRL_CLEAR_BIT]) else $error("clear bit stuck");
    chk_brake_flag_set: assert property (
        brake_i && ben_r |=> brake_irq_o) else $error("brake flag not set");
    chk_brake_flag_sticky: assert property (
        brake_irq_o && !(sfr_wr_i && sfr_addr_i == ADDR_BRAKE_OUT_CTRL && !sfr_wdata_i[BRAKE_FLAG_BIT])
        |=> brake_irq_o) else $error("brake flag dropped");
    chk_stopped_outputs: assert property (
        !run_r && !cw && !$past(cw, 1) && !$past(cw, 2) && !$past(cw, 3) |=> $stable(pwm_o))
        else $error("outputs moved while stopped");
    cover property (brake_irq_o);
    cover property (cw && sfr_wdata_i[CTRL_LOAD_BIT]);
    cover property (rc);
    cover property (cw && sfr_wdata_i[CTRL_CLEAR_BIT]);
endmodule
bind fcp_core fcp_core_props #(.W(W)) u_props (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .brake_i(brake_i), .brake_irq_o(brake_irq_o), .pwm_o(pwm_o));

// ===== dv/fcp_core_tb.sv
// Self-checking bench for the modulator core
`timescale 1ns/10ps
module fcp_core_tb
    import fcp_pkg::*;
;
    localparam logic [7:0] CTL = ADDR_MAIN_CTRL;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic brake_i = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic brake_irq_o;
    logic [3:0] pwm_o;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    fcp_core #(.W(10)) uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
        .brake_i(brake_i), .brake_irq_o(brake_irq_o), .pwm_o(pwm_o));
    initial
        forever #4 ref_clk_i = ~ref_clk_i;
    // ****
    // Helpers
    // ****
    task automatic complete_run();
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_rd_i <= 1'b0;
        #1;
        chk(sfr_rdata_o, exp);
    endtask
    task automatic pulse();
        @(posedge ref_clk_i);
        brake_i <= 1'b1;
        @(posedge ref_clk_i);
        brake_i <= 1'b0;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        rd(CTL, REG_RESET);
        rd(ADDR_BRAKE_OUT_CTRL, REG_RESET);
        rd(ADDR_CHAN2_DUTY_LOW, REG_RESET);
        wr(ADDR_CHAN2_DUTY_LOW, 8'hA5);
        wr(ADDR_CHAN3_DUTY_LOW, 8'h5A);
        wr(8'hD9, 8'hFF);
        rd(ADDR_CHAN2_DUTY_LOW, 8'hA5);
        rd(ADDR_CHAN3_DUTY_LOW, 8'h5A);
        rd(8'hD9, 8'h00);
        wr(ADDR_PERIOD_HIGH, 8'hFF);
        rd(ADDR_PERIOD_HIGH, 8'h03);
        wr(ADDR_PERIOD_HIGH, 8'h00);
        rd(ADDR_PERIOD_HIGH, 8'h00);
    endtask
    task automatic t_invert();
        for (int i = 0; i < 4; i++)
        begin
            wr(CTL, 8'h01 << i);
            idle(3);
            chk({4'h0, pwm_o}, 8'h01 << i);
            rd(CTL, 8'h01 << i);
        end
        wr(CTL, 8'h00);
    endtask
    task automatic t_run();
        int hi[4] = '{default: 0};
        wr(ADDR_PERIOD_LOW, 8'h09);
        wr(ADDR_CHAN0_DUTY_LOW, 8'h04);
        wr(ADDR_CHAN1_DUTY_LOW, 8'hFF);
        wr(ADDR_CHAN1_DUTY_HIGH, 8'h03);
        wr(ADDR_CHAN2_DUTY_LOW, 8'h00);
        wr(ADDR_CHAN3_DUTY_LOW, 8'h0A);
        wr(CTL, 8'h80);
        idle(20);
        chk({4'h0, pwm_o}, 8'h00);
        rd(CTL, 8'hA0);
        wr(CTL, 8'hC0);
        rd(CTL, 8'hA0);
        idle(5);
        for (int k = 0; k < 100; k++)
        begin
            for (int c = 0; c < 4; c++)
                hi[c] += pwm_o[c];
            idle(1);
        end
        chk(8'(hi[0]), 8'h28);
        chk(8'(hi[1]), 8'h64);
        chk(8'(hi[2]), 8'h00);
        chk(8'(hi[3]), 8'h64);
    endtask
    task automatic t_stop();
        // Stop with the counter at 8, so the clear is visible on channel 0
        idle(4);
        wr(CTL, 8'h20);
        rd(CTL, 8'h20);
        wr(CTL, 8'h00);
        rd(CTL, 8'h00);
        idle(20);
        rd(CTL, 8'h00);
        chk({4'h0, pwm_o}, 8'h0A);
        wr(CTL, 8'h10);
        idle(4);
        chk({4'h0, pwm_o}, 8'h0B);
        rd(CTL, 8'h00);
    endtask
    task automatic t_brake();
        pulse();
        idle(2);
        chk({7'h00, brake_irq_o}, 8'h00);
        wr(ADDR_BRAKE_OUT_CTRL, 8'h10);
        pulse();
        idle(8);
        chk({7'h00, brake_irq_o}, 8'h01);
        rd(ADDR_BRAKE_OUT_CTRL, 8'h90);
        wr(ADDR_BRAKE_OUT_CTRL, 8'h10);
        rd(ADDR_BRAKE_OUT_CTRL, 8'h10);
        chk({7'h00, brake_irq_o}, 8'h00);
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_invert();
        t_run();
        t_stop();
        t_brake();
        complete_run();
    end
endmodule
